// ### rtl/pts_consts.svh
// offsets, field positions, reset values and timing counts of the paper tape serial controller
`ifndef PTS_CONSTS_SVH
`define PTS_CONSTS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define PTS_CLK_HZ 25000000
`define PTS_BAUD_RESET 110
`define PTS_HALF_BIT_CYCLES (`PTS_CLK_HZ / (2 * `PTS_BAUD_RESET))
`define PTS_DIV_W 20

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PTS_OFS_CTRL 12'h000
`define PTS_OFS_DIVISOR 12'h004
`define PTS_OFS_STATUS 12'h008
`define PTS_OFS_RXDATA 12'h00c

// ----------------------------------------
// control fields
// ----------------------------------------
`define PTS_CTRL_W 15
`define PTS_CTRL_RESET 15'h0001
`define PTS_CTRL_MODE7 0
`define PTS_CTRL_LATE_FW 1
`define PTS_CTRL_LOCAL_PAR 2
`define PTS_CTRL_CUR_VER 3
`define PTS_CTRL_PAR_A 4
`define PTS_CTRL_PAR_B 5
`define PTS_CTRL_CC_EN 6
`define PTS_CTRL_TP_PAR_A 7
`define PTS_CTRL_TP_PAR_B 8

// ----------------------------------------
// status fields
// ----------------------------------------
`define PTS_ST_FIGURES 0
`define PTS_ST_TX_BUSY 1
`define PTS_ST_RX_BUSY 2
`define PTS_ST_PUNCH_BUSY 3
`define PTS_ST_PAR_ERR 4
`define PTS_ST_FRAME_ERR 5
`define PTS_ST_OVERRUN 6

// ----------------------------------------
// character codes and frame shape
// ----------------------------------------
`define PTS_FIGS_CODE 5'h1b
`define PTS_LTRS_CODE 5'h1f
`define PTS_CTL_LIMIT 7'h20
`define PTS_RUBOUT 7'h7f
`define PTS_LAST_BIT_7 3'h6
`define PTS_LAST_BIT_5 3'h4
`define PTS_BIT_HALVES 2'h2
`define PTS_STOP_HALVES_5 2'h3
`define PTS_PAR_SPACE 2'h3

`endif

// ### rtl/pts_pkg.sv
// types of the paper tape serial controller
package pts_pkg;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} pts_tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} pts_rx_state_t;
    typedef enum logic [1:0] {PU_IDLE, PU_WAIT, PU_FIRE} pts_punch_state_t;
endpackage

// ### rtl/pts_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
`default_nettype none
module pts_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // pins and synchronised copies
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic meta;
            always_ff @(posedge clk_i) begin
                if (!rstn_i) begin
                    meta <= 1'h0;
                    q_o[g] <= 1'h0;
                end else begin
                    meta <= d_i[g];
                    q_o[g] <= meta;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ### rtl/pts_skid.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module pts_skid #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // filling side
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    // draining side
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    logic [W-1:0] mem [0:1];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] cnt;
    logic [1:0] next_cnt;
    wire push = in_valid_i & in_ready_o;
    wire pop = out_valid_o & out_ready_i;

    assign in_ready_o = (cnt != 2'h2);
    assign out_valid_o = (cnt != 2'h0);
    assign out_data_o = mem[rd_ptr];
    assign next_cnt = (push & ~pop) ? cnt + 2'h1 : (pop & ~push) ? cnt - 2'h1 : cnt;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            wr_ptr <= 1'h0;
            rd_ptr <= 1'h0;
            cnt <= 2'h0;
        end else begin
            wr_ptr <= wr_ptr ^ push;
            rd_ptr <= rd_ptr ^ pop;
            cnt <= next_cnt;
        end
    end
endmodule
`default_nettype wire

// ### rtl/pts_controller.sv
// paper tape serial controller: reader to line, line to punch, apb option registers
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "pts_consts.svh"
module pts_controller import pts_pkg::*; #(
    parameter int HALF_BIT_RESET = `PTS_HALF_BIT_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // tape reader
    input wire logic [7:0] reader_holes_i,
    input wire logic reader_strobe_i,
    output logic reader_ready_o,
    // serial line to teleprinter
    input wire logic rxd_i,
    output logic txd_o,
    // tape punch
    input wire logic punch_shaft_i,
    output logic [7:0] punch_needles_o,
    output logic punch_feed_o
);
    // ----------------------------------------
    // pin synchronisers and edges
    // ----------------------------------------
    logic [10:0] sync_q;
    logic strobe_prev;
    logic shaft_prev;
    logic rxd_prev;
    wire [7:0] holes_s = sync_q[7:0];
    wire rxd_s = sync_q[8];
    wire strobe_s = sync_q[9];
    wire shaft_s = sync_q[10];
    wire strobe_rise = strobe_s & ~strobe_prev;
    wire shaft_rise = shaft_s & ~shaft_prev;
    wire rx_fall = ~rxd_s & rxd_prev;

    pts_sync #(.W(11)) u_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .d_i({punch_shaft_i, reader_strobe_i, rxd_i, reader_holes_i}),
        .q_o(sync_q)
    );

    // ----------------------------------------
    // option registers and decode
    // ----------------------------------------
    logic [`PTS_CTRL_W-1:0] ctrl;
    logic [`PTS_DIV_W-1:0] divisor;
    logic [6:0] last_rx;
    logic figures;
    logic st_par;
    logic st_frame;
    logic st_over;
    // unused switch bits are stored and read back only
    wire mode7 = ctrl[`PTS_CTRL_MODE7];
    wire cur_ver = ctrl[`PTS_CTRL_CUR_VER];
    wire cc_en = ctrl[`PTS_CTRL_CC_EN];
    wire [1:0] local_kind = {ctrl[`PTS_CTRL_PAR_A], ctrl[`PTS_CTRL_PAR_B]};
    wire [1:0] tele_kind = {ctrl[`PTS_CTRL_TP_PAR_A], ctrl[`PTS_CTRL_TP_PAR_B]};
    // early firmware ignores block one for line parity; the eighth punch hole still uses it
    wire use_local = ctrl[`PTS_CTRL_LATE_FW] & ctrl[`PTS_CTRL_LOCAL_PAR];
    wire [1:0] line_kind = use_local ? local_kind : tele_kind;
    wire [6:0] mask = mode7 ? 7'h7f : 7'h1f;
    wire [2:0] last_bit = mode7 ? `PTS_LAST_BIT_7 : `PTS_LAST_BIT_5;

    // 00 odd, 01 even, 10 mark, 11 space/off
    function automatic logic par_of(input logic [1:0] k, input logic [6:0] d);
        logic p;
        p = 1'h0;
        case (k)
            2'h0: p = ~^d;
            2'h1: p = ^d;
            2'h2: p = 1'h1;
            default: p = 1'h0;
        endcase
        return p;
    endfunction

    // ----------------------------------------
    // reader latch and buffer
    // ----------------------------------------
    logic rd_valid;
    logic [7:0] rd_latch;
    logic buf_in_ready;
    logic buf_valid;
    logic [7:0] buf_data;
    logic buf_ready;
    wire rd_take = strobe_rise & ~rd_valid;
    wire next_rd_valid = rd_take | (rd_valid & ~buf_in_ready);
    // eighth hole dropped on early units
    wire [7:0] holes_kept = cur_ver ? holes_s : {1'h0, holes_s[6:0]};

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rd_valid <= 1'h0;
            rd_latch <= 8'h00;
            reader_ready_o <= 1'h0;
        end else begin
            rd_valid <= next_rd_valid;
            reader_ready_o <= ~next_rd_valid;
            if (rd_take) begin
                rd_latch <= holes_kept;
            end
        end
    end

    // no filtering: nulls and rubouts pass like any code
    pts_skid #(.W(8)) u_buf (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .in_valid_i(rd_valid),
        .in_data_i(rd_latch),
        .in_ready_o(buf_in_ready),
        .out_valid_o(buf_valid),
        .out_data_o(buf_data),
        .out_ready_i(buf_ready)
    );

    // ----------------------------------------
    // transmitter
    // ----------------------------------------
    pts_tx_state_t tx_state, next_tx_state;
    logic [`PTS_DIV_W-1:0] tx_div, next_tx_div;
    logic [1:0] tx_half, next_tx_half;
    logic [2:0] tx_bit, next_tx_bit;
    logic [6:0] tx_sh, next_tx_sh;
    logic tx_par, next_tx_par;
    wire tx_tick = (tx_div == divisor - 20'h00001);
    // stop lasts two halves in 7-bit mode, three in 5-bit mode
    wire [1:0] tx_lim = (tx_state == TX_STOP && !mode7) ? `PTS_STOP_HALVES_5 : `PTS_BIT_HALVES;
    wire tx_end = tx_tick & (tx_half == tx_lim - 2'h1);
    wire [6:0] tx_load = buf_data[6:0] & mask;
    wire tx_line = (tx_state == TX_START) ? 1'h0 :
                   (tx_state == TX_DATA) ? tx_sh[0] :
                   (tx_state == TX_PAR) ? tx_par : 1'h1;
    assign buf_ready = (tx_state == TX_IDLE);

    always_comb begin
        next_tx_state = tx_state;
        next_tx_div = tx_tick ? 20'h00000 : tx_div + 20'h00001;
        next_tx_half = tx_tick ? tx_half + 2'h1 : tx_half;
        next_tx_bit = tx_bit;
        next_tx_sh = tx_sh;
        next_tx_par = tx_par;
        case (tx_state)
            TX_IDLE: begin
                next_tx_div = 20'h00000;
                next_tx_half = 2'h0;
                if (buf_valid) begin
                    next_tx_state = TX_START;
                    next_tx_sh = tx_load;
                    next_tx_par = par_of(line_kind, tx_load);
                end
            end
            TX_START: begin
                if (tx_end) begin
                    next_tx_state = TX_DATA;
                    next_tx_half = 2'h0;
                    next_tx_bit = 3'h0;
                end
            end
            TX_DATA: begin
                if (tx_end) begin
                    next_tx_half = 2'h0;
                    next_tx_sh = {1'h0, tx_sh[6:1]};
                    next_tx_bit = tx_bit + 3'h1;
                    if (tx_bit == last_bit) begin
                        next_tx_state = TX_PAR;
                    end
                end
            end
            TX_PAR: begin
                if (tx_end) begin
                    next_tx_state = TX_STOP;
                    next_tx_half = 2'h0;
                end
            end
            TX_STOP: begin
                if (tx_end) begin
                    next_tx_state = TX_IDLE;
                end
            end
            default: next_tx_state = TX_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            tx_state <= TX_IDLE;
            tx_div <= 20'h00000;
            tx_half <= 2'h0;
            tx_bit <= 3'h0;
            tx_sh <= 7'h00;
            tx_par <= 1'h0;
            txd_o <= 1'h1;
        end else begin
            tx_state <= next_tx_state;
            tx_div <= next_tx_div;
            tx_half <= next_tx_half;
            tx_bit <= next_tx_bit;
            tx_sh <= next_tx_sh;
            tx_par <= next_tx_par;
            txd_o <= tx_line;
        end
    end

    // ----------------------------------------
    // receiver
    // ----------------------------------------
    pts_rx_state_t rx_state, next_rx_state;
    logic [`PTS_DIV_W-1:0] rx_div, next_rx_div;
    logic [1:0] rx_half, next_rx_half;
    logic [2:0] rx_bit, next_rx_bit;
    logic [6:0] rx_sh, next_rx_sh;
    logic rx_par_bit, next_rx_par_bit;
    wire rx_tick = (rx_div == divisor - 20'h00001);
    // start waits one half to sample at bit centre
    wire [1:0] rx_lim = (rx_state == RX_START) ? 2'h1 : `PTS_BIT_HALVES;
    wire rx_end = rx_tick & (rx_half == rx_lim - 2'h1);
    wire rx_fin = (rx_state == RX_STOP) & rx_end;
    wire [4:0] rx_char5 = rx_sh[6:2];
    wire [6:0] rx_char = mode7 ? rx_sh : {2'h0, rx_char5};
    wire par_bad = rx_fin & (line_kind != `PTS_PAR_SPACE) & (rx_par_bit != par_of(line_kind, rx_char));
    wire frame_bad = rx_fin & ~rxd_s;

    always_comb begin
        next_rx_state = rx_state;
        next_rx_div = rx_tick ? 20'h00000 : rx_div + 20'h00001;
        next_rx_half = rx_tick ? rx_half + 2'h1 : rx_half;
        next_rx_bit = rx_bit;
        next_rx_sh = rx_sh;
        next_rx_par_bit = rx_par_bit;
        case (rx_state)
            RX_IDLE: begin
                next_rx_div = 20'h00000;
                next_rx_half = 2'h0;
                if (rx_fall) begin
                    next_rx_state = RX_START;
                end
            end
            RX_START: begin
                if (rx_end) begin
                    next_rx_half = 2'h0;
                    next_rx_bit = 3'h0;
                    next_rx_state = rxd_s ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rx_end) begin
                    next_rx_half = 2'h0;
                    next_rx_sh = {rxd_s, rx_sh[6:1]};
                    next_rx_bit = rx_bit + 3'h1;
                    if (rx_bit == last_bit) begin
                        next_rx_state = RX_PAR;
                    end
                end
            end
            RX_PAR: begin
                if (rx_end) begin
                    next_rx_half = 2'h0;
                    next_rx_par_bit = rxd_s;
                    next_rx_state = RX_STOP;
                end
            end
            RX_STOP: begin
                if (rx_end) begin
                    next_rx_state = RX_IDLE;
                end
            end
            default: next_rx_state = RX_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rx_state <= RX_IDLE;
            rx_div <= 20'h00000;
            rx_half <= 2'h0;
            rx_bit <= 3'h0;
            rx_sh <= 7'h00;
            rx_par_bit <= 1'h0;
        end else begin
            rx_state <= next_rx_state;
            rx_div <= next_rx_div;
            rx_half <= next_rx_half;
            rx_bit <= next_rx_bit;
            rx_sh <= next_rx_sh;
            rx_par_bit <= next_rx_par_bit;
        end
    end

    // ----------------------------------------
    // shift state and punch holding latch
    // ----------------------------------------
    logic [7:0] hold_latch;
    logic hold_full;
    pts_punch_state_t pu_state, next_pu_state;
    wire rx_ctl = (rx_char < `PTS_CTL_LIMIT) | (rx_char == `PTS_RUBOUT);
    wire rx_punch = rx_fin & ~(mode7 & rx_ctl & ~cc_en);
    wire hold_load = rx_punch & ~hold_full;
    wire overrun = rx_punch & hold_full;
    wire pu_done = (pu_state == PU_FIRE) & shaft_rise;
    wire eighth = cur_ver & par_of(local_kind, rx_char);
    wire [7:0] punch_word = mode7 ? {eighth, rx_char} : {3'h0, rx_char5};
    wire set_figs = rx_fin & ~mode7 & (rx_char5 == `PTS_FIGS_CODE);
    wire set_ltrs = rx_fin & ~mode7 & (rx_char5 == `PTS_LTRS_CODE);

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            figures <= 1'h0;
            hold_latch <= 8'h00;
            hold_full <= 1'h0;
            last_rx <= 7'h00;
        end else begin
            if (set_figs) begin
                figures <= 1'h1;
            end else if (set_ltrs) begin
                figures <= 1'h0;
            end
            if (rx_fin) begin
                last_rx <= rx_char;
            end
            if (hold_load) begin
                hold_latch <= punch_word;
            end
            hold_full <= hold_load | (hold_full & ~pu_done);
        end
    end

    // ----------------------------------------
    // punch sequencer
    // ----------------------------------------
    always_comb begin
        next_pu_state = pu_state;
        case (pu_state)
            PU_IDLE: begin
                if (hold_full) begin
                    next_pu_state = PU_WAIT;
                end
            end
            PU_WAIT: begin
                if (shaft_rise) begin
                    next_pu_state = PU_FIRE;
                end
            end
            PU_FIRE: begin
                if (shaft_rise) begin
                    next_pu_state = PU_IDLE;
                end
            end
            default: next_pu_state = PU_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pu_state <= PU_IDLE;
            punch_needles_o <= 8'h00;
            punch_feed_o <= 1'h0;
        end else begin
            pu_state <= next_pu_state;
            punch_needles_o <= (next_pu_state == PU_FIRE) ? hold_latch : 8'h00;
            punch_feed_o <= (next_pu_state == PU_FIRE);
        end
    end

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    wire hit_ctrl = (paddr_i == `PTS_OFS_CTRL);
    wire hit_div = (paddr_i == `PTS_OFS_DIVISOR);
    wire hit_st = (paddr_i == `PTS_OFS_STATUS);
    wire hit_rx = (paddr_i == `PTS_OFS_RXDATA);
    wire hit = hit_ctrl | hit_div | hit_st | hit_rx;
    wire acc = psel_i & penable_i & ~pready_o;
    wire wr = psel_i & penable_i & pready_o & pwrite_i & hit;
    wire st_clr = wr & hit_st;
    wire [6:0] status = {st_over, st_frame, st_par, (pu_state != PU_IDLE) | hold_full,
                         rx_state != RX_IDLE, (tx_state != TX_IDLE) | buf_valid, figures};
    wire [31:0] rd_word = hit_ctrl ? {17'h0_0000, ctrl} :
                          hit_div ? {12'h000, divisor} :
                          hit_st ? {25'h000_0000, status} :
                          hit_rx ? {25'h000_0000, last_rx} : 32'h0000_0000;
    wire [`PTS_DIV_W-1:0] div_wr = (pwdata_i[19:0] == 20'h00000) ? 20'h00001 : pwdata_i[19:0];

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pready_o <= 1'h0;
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'h0;
            ctrl <= `PTS_CTRL_RESET;
            divisor <= HALF_BIT_RESET[`PTS_DIV_W-1:0];
            st_par <= 1'h0;
            st_frame <= 1'h0;
            st_over <= 1'h0;
        end else begin
            pready_o <= acc;
            prdata_o <= acc ? rd_word : 32'h0000_0000;
            pslverr_o <= acc & ~hit;
            if (wr & hit_ctrl) begin
                ctrl <= pwdata_i[`PTS_CTRL_W-1:0];
            end
            if (wr & hit_div) begin
                divisor <= div_wr;
            end
            // set wins over write-one-to-clear
            st_par <= par_bad | (st_par & ~(st_clr & pwdata_i[`PTS_ST_PAR_ERR]));
            st_frame <= frame_bad | (st_frame & ~(st_clr & pwdata_i[`PTS_ST_FRAME_ERR]));
            st_over <= overrun | (st_over & ~(st_clr & pwdata_i[`PTS_ST_OVERRUN]));
        end
    end

    // ----------------------------------------
    // edge history
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            strobe_prev <= 1'h0;
            shaft_prev <= 1'h0;
            rxd_prev <= 1'h0;
        end else begin
            strobe_prev <= strobe_s;
            shaft_prev <= shaft_s;
            rxd_prev <= rxd_s;
        end
    end
endmodule
`default_nettype wire

// ### test/pts_controller_monitor.sv
// assertion checker on the ports of the paper tape serial controller
`timescale 1ns/1ns
`default_nettype none
module pts_controller_monitor #(
    parameter int HALF_BIT_RESET = 4
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // reader, line and punch
    input wire logic reader_strobe_i,
    input wire logic reader_ready_o,
    input wire logic txd_o,
    input wire logic punch_shaft_i,
    input wire logic [7:0] punch_needles_o,
    input wire logic punch_feed_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    logic txd_q;
    logic [19:0] run;
    // cycles the line has kept its level
    always_ff @(posedge clk_i) begin
        txd_q <= rstn_i ? txd_o : 1'b1;
        run <= (!rstn_i || txd_o != txd_q) ? 20'h0_0001 : run + 20'h0_0001;
    end
    sequence access_s;
        psel_i && penable_i && !pready_o;
    endsequence
    sequence answer_s;
        pready_o ##1 !pready_o;
    endsequence
    ready_wait_a: assert property (access_s |=> answer_s) else $error("apb answer late or long");
    err_ready_a: assert property (pslverr_o |-> pready_o) else $error("pslverr without pready");
    rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0000_0000) else $error("prdata outside answer");
    bit_len_a: assert property (txd_o != txd_q |-> run >= 2 * HALF_BIT_RESET)
        else $error("line bit too short");
    needles_idle_a: assert property (!punch_feed_o |-> punch_needles_o == 8'h00)
        else $error("needles outside feed window");
    feed_start_a: assert property ($rose(punch_feed_o) |-> punch_shaft_i) else $error("feed not on shaft");
    feed_stop_a: assert property ($fell(punch_feed_o) |-> punch_shaft_i) else $error("feed end off shaft");
    feed_held_a: assert property ($rose(punch_feed_o) |-> punch_feed_o[*8]) else $error("feed too short");
    reader_take_a: assert property ($fell(reader_ready_o) |-> reader_strobe_i) else $error("reader taken alone");
endmodule
bind pts_controller pts_controller_monitor #(.HALF_BIT_RESET(HALF_BIT_RESET)) mon (
    .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .reader_strobe_i(reader_strobe_i),
    .reader_ready_o(reader_ready_o), .txd_o(txd_o), .punch_shaft_i(punch_shaft_i),
    .punch_needles_o(punch_needles_o), .punch_feed_o(punch_feed_o));
`default_nettype wire

// ### test/pts_teleprinter.sv
// teleprinter model: frames into and out of the controller
`timescale 1ns/1ns
`default_nettype none
module pts_teleprinter #(
    parameter int BIT = 8
) (
    // clock
    input wire logic clk_i,
    // serial line
    input wire logic txd_i,
    output logic rxd_o
);
    initial rxd_o = 1'b1;
    // lsb first, then mark for stop and idle
    task automatic send(input logic [9:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            rxd_o <= f[i];
            repeat (BIT) @(posedge clk_i);
        end
        rxd_o <= 1'b1;
        repeat (2 * BIT) @(posedge clk_i);
    endtask
    // centre samples of data, parity and stop
    task automatic recv(output logic [8:0] d);
        int n;
        for (n = 0; n < 4000 && txd_i; n++) @(posedge clk_i);
        if (n == 4000) tb_paper_tape_serial_controller.give_up();
        repeat (BIT / 2) @(posedge clk_i);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT) @(posedge clk_i);
            d[i] = txd_i;
        end
    endtask
endmodule
`default_nettype wire

// ### test/tb_paper_tape_serial_controller.sv
// self-checking bench of the paper tape serial controller
`timescale 1ns/1ns
`default_nettype none
module tb_paper_tape_serial_controller;
    localparam int HB = 4;
    logic clk_i = 1'b0, rstn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic reader_strobe_i = 1'b0, punch_shaft_i = 1'b0, pready_o, pslverr_o, reader_ready_o;
    logic rxd_i, txd_o, punch_feed_o, perr;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rd;
    logic [7:0] reader_holes_i = 8'h00, punch_needles_o;
    logic [8:0] fr;
    int num_errors = 0, comparisons = 0;
    always #20 clk_i = ~clk_i;
    pts_controller #(.HALF_BIT_RESET(HB)) uut (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .reader_holes_i(reader_holes_i),
        .reader_strobe_i(reader_strobe_i), .reader_ready_o(reader_ready_o), .rxd_i(rxd_i), .txd_o(txd_o),
        .punch_shaft_i(punch_shaft_i), .punch_needles_o(punch_needles_o), .punch_feed_o(punch_feed_o));
    pts_teleprinter #(.BIT(2 * HB)) tp (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic give_up;
        num_errors++;
        summarize();
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        for (n = 0; n < 20 && pready_o !== 1'b1; n++) @(posedge clk_i);
        if (n == 20) give_up();
        rd = prdata_o;
        perr = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic feed_reader(input logic [7:0] ch);
        int n;
        @(posedge clk_i);
        reader_holes_i <= ch;
        reader_strobe_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        reader_strobe_i <= 1'b0;
        for (n = 0; n < 400 && reader_ready_o !== 1'b1; n++) @(posedge clk_i);
        if (n == 400) give_up();
    endtask
    task automatic shaft;
        punch_shaft_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        punch_shaft_i <= 1'b0;
        repeat (10) @(posedge clk_i);
    endtask
    task automatic test_regs;
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b1, 12'h010, 32'hffff_ffff);
        chk({31'h0, perr}, 32'h0000_0001);
    endtask
    task automatic test_send;
        fork
            begin
                feed_reader(8'h80);
                feed_reader(8'h7f);
            end
            begin
                tp.recv(fr);
                chk({23'h0, fr}, 32'h0000_0180);
                tp.recv(fr);
                chk({23'h0, fr}, 32'h0000_017f);
            end
        join
    endtask
    task automatic test_punch;
        tp.send({1'b1, ~^7'h05, 7'h05, 1'b0}, 10);
        tp.send({1'b1, ~^7'h41, 7'h41, 1'b0}, 10);
        shaft();
        chk({23'h0, punch_feed_o, punch_needles_o}, 32'h0000_0141);
        shaft();
        chk({23'h0, punch_feed_o, punch_needles_o}, 32'h0000_0000);
        apb(1'b1, 12'h000, 32'h0000_7e2f);
        tp.send({1'b1, ^7'h43, 7'h43, 1'b0}, 10);
        shaft();
        chk({23'h0, punch_feed_o, punch_needles_o}, 32'h0000_01c3);
        shaft();
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk(rd & 32'h0000_0010, 32'h0000_0000);
    endtask
    task automatic test_shift;
        apb(1'b1, 12'h000, 32'h0000_0024);
        fork
            feed_reader(8'h1f);
            tp.recv(fr);
        join
        chk({23'h0, fr}, 32'h0000_01df);
        tp.send({3'b111, ~^5'h1b, 5'h1b, 1'b0}, 7);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk(rd & 32'h0000_0011, 32'h0000_0001);
        tp.send({3'b111, ~^5'h1f, 5'h1f, 1'b0}, 7);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk(rd & 32'h0000_0001, 32'h0000_0000);
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        rstn_i <= 1'b1;
        test_regs();
        test_send();
        test_punch();
        test_shift();
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        give_up();
    end
endmodule
`default_nettype wire
